/* File: dpc_pkg.sv */
package dpc_pkg;
  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int DPC_POTS = 2;          // two potentiometers
  localparam int DPC_SLOTS = 4;         // nonvolatile slots per pot
  localparam int DPC_TAPS = 256;        // taps per pot
  // device type code, value is arbitrary
  localparam logic [3:0] DPC_TYPE_CODE = 4'ha;
  // instruction opcodes (upper nibble of instruction byte)
  localparam logic [3:0] DPC_OP_RD_WIPER = 4'h9;
  localparam logic [3:0] DPC_OP_WR_WIPER = 4'ha;
  localparam logic [3:0] DPC_OP_RD_SLOT = 4'hb;
  localparam logic [3:0] DPC_OP_WR_SLOT = 4'hc;
  localparam logic [3:0] DPC_OP_SLOT_TO_WIPER = 4'hd;
  localparam logic [3:0] DPC_OP_WIPER_TO_SLOT = 4'he;
  // reset values
  localparam logic [7:0] DPC_SLOT_RST = 8'h80;
  localparam logic [7:0] DPC_WIPER_RST = 8'h00;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int DPC_CLK_MHZ = 200;
  localparam int DPC_NVWRITE_US = 5000;  // 5 ms write cycle
  localparam int DPC_NVWRITE_CYC = DPC_NVWRITE_US * DPC_CLK_MHZ;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic scl;      // serial clock in
    logic sda_in;   // sampled data line
  } dpc_bus_in_t;

  typedef struct packed {
    logic sda_out;  // always 0 when driving (open drain)
    logic sda_oe;   // high while pulling the line low
  } dpc_bus_out_t;

  typedef enum logic [2:0] {
    DPC_IDLE, DPC_ADDR, DPC_INSTR, DPC_DATA, DPC_SEND, DPC_IGNORE
  } dpc_state_t;
endpackage

/* File: dpc_ctrl.sv */
module dpc_ctrl
  import dpc_pkg::*;
#(
  parameter int NVWRITE_CYC = DPC_NVWRITE_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // serial link
  input wire dpc_bus_in_t bus_in,
  output dpc_bus_out_t bus_out,
  // straps and guard
  input wire logic [3:0] address_strap_pins,
  input wire logic write_guard_n,
  // potentiometer taps, one-hot per pot
  output logic [DPC_TAPS-1:0] tap_sel0,
  output logic [DPC_TAPS-1:0] tap_sel1,
  // status
  output logic nv_busy
);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [7:0] wiper_position_reg [DPC_POTS];     // volatile wipers
  logic [7:0] slot_mem [DPC_POTS][DPC_SLOTS];    // nonvolatile slots
  logic recall_done;                             // power-up recall flag

  // ------------------------------------------------------------
  // line edge detection
  // ------------------------------------------------------------
  logic scl_q, sda_q;
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = bus_in.scl & ~scl_q;
  assign scl_fall = ~bus_in.scl & scl_q;
  // start / stop while clock high
  assign start_c = bus_in.scl & scl_q & sda_q & ~bus_in.sda_in;
  assign stop_c = bus_in.scl & scl_q & ~sda_q & bus_in.sda_in;

  // previous line levels
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= bus_in.scl;
      sda_q <= bus_in.sda_in;
    end
  end

  // ------------------------------------------------------------
  // byte engine
  // ------------------------------------------------------------
  dpc_state_t state;
  logic [7:0] shreg;       // incoming shift register
  logic [3:0] bitcnt;      // 0..9, 8 is the ack slot, 9 after the ninth clock
  logic [7:0] instr;       // latched instruction byte
  logic [7:0] txbyte;      // outgoing data
  logic ack_drive;         // pull low during ack slot
  logic tx_drive;          // pull low for a zero data bit
  logic master_nack;       // master declined further bytes
  logic nv_pending;        // slot write waiting for stop
  logic [31:0] nv_cnt;     // write cycle countdown
  logic [7:0] rx_byte;
  assign rx_byte = {shreg[6:0], bus_in.sda_in};

  // decoded instruction fields
  logic [3:0] op;
  logic [1:0] slot;
  logic pot;
  assign op = instr[7:4];
  assign slot = {instr[3], instr[2]};  // slot_select_high, _low
  assign pot = instr[0];

  // read data for the current instruction
  logic [7:0] rd_val;
  always_comb begin
    rd_val = wiper_position_reg[pot];
    if (op == DPC_OP_RD_SLOT) begin
      rd_val = slot_mem[pot][slot];
    end
  end

  // identification byte check, valid once eight bits are in
  logic id_match;  // type code, strap address, not busy
  logic addr_hit;  // address check kept for the ninth clock
  logic rd_op;     // latched instruction is a read
  // low address bits come from the strap pins
  // type code high nibble, address low nibble
  // a busy device does not answer its address
  assign id_match = shreg[7:4] == DPC_TYPE_CODE &&
                    shreg[3:0] == address_strap_pins && !nv_busy;
  assign rd_op = op == DPC_OP_RD_WIPER || op == DPC_OP_RD_SLOT;

  // protocol state machine; a start always restarts decoding
  // bitcnt: 0..7 data bits, 8 ack slot, 9 ninth clock seen
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= DPC_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      instr <= 8'h00;
      master_nack <= 1'b0;
      addr_hit <= 1'b0;
    end else if (start_c) begin
      state <= DPC_ADDR;
      bitcnt <= 4'h0;
    end else if (stop_c) begin
      state <= DPC_IDLE;
      bitcnt <= 4'h0;
    end else if (scl_rise) begin
      if (bitcnt == 4'h8) begin
        // ninth clock: master answer during a read
        master_nack <= bus_in.sda_in;
        bitcnt <= 4'h9;
      end else if (bitcnt < 4'h8) begin
        bitcnt <= bitcnt + 4'h1;
        if (state != DPC_SEND) begin
          shreg <= rx_byte;
        end
      end
    end else if (scl_fall && bitcnt == 4'h8) begin
      // eighth bit complete, ack slot opens
      if (state == DPC_ADDR) begin
        // go on only after a matching address
        addr_hit <= id_match;
      end else if (state == DPC_INSTR) begin
        instr <= shreg;
      end
    end else if (scl_fall && bitcnt == 4'h9) begin
      // ninth clock over, choose the next phase
      bitcnt <= 4'h0;
      case (state)
        DPC_ADDR: state <= addr_hit ? DPC_INSTR : DPC_IGNORE;
        DPC_INSTR: begin
          if (rd_op) begin
            state <= DPC_SEND;
          end else if (op == DPC_OP_WR_WIPER ||
                       op == DPC_OP_WR_SLOT) begin
            state <= DPC_DATA;
          end else begin
            state <= DPC_IGNORE;
          end
        end
        DPC_DATA: state <= DPC_IGNORE;  // one data byte only
        DPC_SEND: state <= master_nack ? DPC_IGNORE : DPC_SEND;
        default: state <= DPC_IGNORE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // open-drain output
  // ------------------------------------------------------------
  // outgoing bit changes only after falling edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_drive <= 1'b0;
      tx_drive <= 1'b0;
      txbyte <= 8'h00;
    end else if (start_c || stop_c) begin
      ack_drive <= 1'b0;
      tx_drive <= 1'b0;
    end else if (scl_fall) begin
      ack_drive <= 1'b0;
      tx_drive <= 1'b0;
      if (bitcnt == 4'h8) begin
        // receiver acks; a sender leaves the line to the master
        if (state == DPC_ADDR) begin
          // no ack to address while write cycle runs
          ack_drive <= id_match;
        end else if (state == DPC_INSTR || state == DPC_DATA) begin
          ack_drive <= 1'b1;
        end
      end else if (bitcnt == 4'h9) begin
        // first bit of a read byte goes out now
        if ((state == DPC_INSTR && rd_op) ||
            (state == DPC_SEND && !master_nack)) begin
          txbyte <= rd_val;
          tx_drive <= ~rd_val[7];
        end
      end else if (state == DPC_SEND && bitcnt != 4'h0) begin
        tx_drive <= ~txbyte[3'(4'h7 - bitcnt)];
      end
    end
  end

  // only pull low, never drive high
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_out <= '0;
    end else begin
      bus_out.sda_out <= 1'b0;
      bus_out.sda_oe <= ack_drive || tx_drive;
    end
  end

  // ------------------------------------------------------------
  // register writes and nonvolatile cycle
  // ------------------------------------------------------------
  // wipers and slots per pot; recall after reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < DPC_POTS; p++) begin
        wiper_position_reg[p] <= DPC_WIPER_RST;
        for (int s = 0; s < DPC_SLOTS; s++) begin
          slot_mem[p][s] <= DPC_SLOT_RST;
        end
      end
      recall_done <= 1'b0;
      nv_pending <= 1'b0;
    end else begin
      if (!recall_done) begin
        recall_done <= 1'b1;
        for (int p = 0; p < DPC_POTS; p++) begin
          wiper_position_reg[p] <= slot_mem[p][0];
        end
      end
      if (state == DPC_DATA && scl_fall && bitcnt == 4'h8) begin
        if (op == DPC_OP_WR_WIPER) begin
          wiper_position_reg[pot] <= shreg;
        end else if (write_guard_n) begin
          slot_mem[pot][slot] <= shreg;
          nv_pending <= 1'b1;
        end
      end
      if (start_c) begin
        nv_pending <= 1'b0;  // no write cycle without stop; the slot keeps the new value
      end else if (stop_c) begin
        nv_pending <= 1'b0;
      end
    end
  end

  // busy for the write cycle after the stop
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nv_cnt <= '0;
      nv_busy <= 1'b0;
    end else if (stop_c && nv_pending) begin
      nv_cnt <= 32'(NVWRITE_CYC);
      nv_busy <= 1'b1;
    end else if (nv_cnt > 32'h1) begin
      nv_cnt <= nv_cnt - 32'h1;
    end else begin
      nv_cnt <= '0;
      nv_busy <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // tap decode
  // ------------------------------------------------------------
  // wiper picks one tap; one-hot from a register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tap_sel0 <= '0;
      tap_sel1 <= '0;
      tap_sel0[0] <= 1'b1;
      tap_sel1[0] <= 1'b1;
    end else begin
      tap_sel0 <= DPC_TAPS'(1) << wiper_position_reg[0];
      tap_sel1 <= DPC_TAPS'(1) << wiper_position_reg[1];
    end
  end

endmodule

/* File: dpc_sva.sv */
module dpc_sva
  import dpc_pkg::*;
#(
  parameter int NVWRITE_CYC = DPC_NVWRITE_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // serial link
  input wire dpc_bus_in_t bus_in,
  input wire dpc_bus_out_t bus_out,
  // straps and guard
  input wire logic [3:0] address_strap_pins,
  input wire logic write_guard_n,
  // taps and status
  input wire logic [DPC_TAPS-1:0] tap_sel0,
  input wire logic [DPC_TAPS-1:0] tap_sel1,
  input wire logic nv_busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  int busy_len; // cycles spent in the current write
  // ----------------------------------------------
  // helper: count busy cycles, too long for [*n]
  // ----------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_len <= 0;
    end else begin
      busy_len <= nv_busy ? busy_len + 1 : 0;
    end
  end
  // ----------------------------------------------
  // checks
  // ----------------------------------------------
  a_drive_low_only: assert property (!bus_out.sda_out)
    else $error("sda driven high");
  a_tap_hot0: assert property ($onehot(tap_sel0))
    else $error("pot 0 taps not one-hot");
  a_tap_hot1: assert property ($onehot(tap_sel1))
    else $error("pot 1 taps not one-hot");
  a_oe_in_low: assert property ($changed(bus_out.sda_oe) |-> !bus_in.scl)
    else $error("sda changed while scl high");
  a_busy_silent: assert property (nv_busy |-> !bus_out.sda_oe)
    else $error("answer given while busy");
  a_busy_length: assert property ($fell(nv_busy) |->
    busy_len inside {[NVWRITE_CYC-1:NVWRITE_CYC+1]})
    else $error("write cycle length wrong");
  a_guard_blocks: assert property ($rose(nv_busy) |-> write_guard_n)
    else $error("slot write under guard");
  a_busy_at_stop: assert property ($rose(nv_busy) |->
    bus_in.scl && bus_in.sda_in)
    else $error("write began outside a stop");
  cover property ($rose(nv_busy));
  cover property ($rose(bus_out.sda_oe));
  cover property ($changed(tap_sel1));
endmodule

bind dpc_ctrl dpc_sva #(.NVWRITE_CYC(NVWRITE_CYC)) u_sva (
  .mclk(mclk), .rst(rst), .bus_in(bus_in), .bus_out(bus_out),
  .address_strap_pins(address_strap_pins), .write_guard_n(write_guard_n),
  .tap_sel0(tap_sel0), .tap_sel1(tap_sel1), .nv_busy(nv_busy));

/* File: dpc_master.sv */
module dpc_master #(
  parameter int HALF = 8
) (
  // clock and line
  input wire logic mclk,
  input wire logic sda,
  // master drives
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  // bus idles high, nobody pulling
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic half();
    repeat (HALF) @(posedge mclk);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic r);
    half();
    sda_low = !b;
    half();
    scl = 1'b1;
    half();
    r = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    sda_low = 1'b0;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
  endtask
  // stop may start a write cycle
  task automatic stop();
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask
  // msb first, ninth bit released for the answer
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rd(input logic ack_me, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!ack_me, r);
  endtask
endmodule

/* File: tb.sv */
module tb
  import dpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------
  // signals
  // ----------------------------------------------
  localparam int NVW = 400; // short write cycle, polls still see it
  logic mclk, rst, scl, m_low, guard_n, a, busy;
  logic [3:0] strap;
  logic [1:0] acks;
  logic [7:0] v, q;
  logic [255:0] t0, t1;
  logic [7:0] wip [2];
  logic [7:0] slot [2][4];
  wire sda;
  dpc_bus_in_t bin;
  dpc_bus_out_t bout;
  int n_fail, n_compared, cyc, seed, p, i, k, g;
  // pull-up: low whenever any party pulls
  assign sda = !(m_low || bout.sda_oe);
  assign bin = {scl, sda};
  dpc_master u_mst (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(m_low));
  dpc_ctrl #(.NVWRITE_CYC(NVW)) u_dut (
    .mclk(mclk), .rst(rst), .bus_in(bin), .bus_out(bout),
    .address_strap_pins(strap), .write_guard_n(guard_n),
    .tap_sel0(t0), .tap_sel1(t1), .nv_busy(busy));
  // ----------------------------------------------
  // clock, timeout, helpers
  // ----------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // a hang counts as a mismatch
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      give_verdict();
    end
  end
  function automatic logic [255:0] tap(input logic [7:0] w);
    return 256'h1 << w;
  endfunction
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one framed command; acks counts bytes answered, stays 1 for a read
  task automatic cmd(input logic [3:0] tc, input logic [3:0] ad,
                     input logic [7:0] ins, input logic [7:0] d);
    acks = 2'h0;
    u_mst.start();
    u_mst.wr({tc, ad}, a);
    if (a) begin
      acks = 2'h1;
      u_mst.wr(ins, a);
      if (a && ins[4]) u_mst.rd(1'b0, q); // read opcodes are odd
      else if (a) begin
        u_mst.wr(d, a);
        acks = a ? 2'h3 : 2'h2;
      end
    end
    u_mst.stop();
  endtask
  // ----------------------------------------------
  // main sequence
  // ----------------------------------------------
  initial begin
    seed = 32'hf39fc486;
    rst = 1'b1;
    strap = 4'h0;
    guard_n = 1'b1;
    repeat (20) @(posedge mclk);
    #1;
    chk(t0, tap(8'h00));
    rst = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk(t0, tap(DPC_SLOT_RST));
    chk(t1, tap(DPC_SLOT_RST));
    wip = '{DPC_SLOT_RST, DPC_SLOT_RST};
    slot = '{default: DPC_SLOT_RST};
    // wiper writes, corner values first, fresh straps each time
    for (i = 0; i < 12; i++) begin
      p = $random(seed) & 1;
      strap = 4'($random(seed));
      v = (i < 2) ? {8{i[0]}} : 8'($random(seed));
      cmd(DPC_TYPE_CODE, strap, {DPC_OP_WR_WIPER, 3'h0, p[0]}, v);
      chk(acks, 2'h3);
      wip[p] = v;
      chk(p ? t1 : t0, tap(v));
      chk(p ? t0 : t1, tap(wip[1-p]));
      cmd(DPC_TYPE_CODE, strap, {DPC_OP_RD_WIPER, 3'h0, p[0]}, 8'h00);
      chk(q, v);
    end
    // each strap bit wrong, then wrong type code
    for (k = 0; k < 5; k++) begin
      cmd(k < 4 ? DPC_TYPE_CODE : DPC_TYPE_CODE ^ 4'h8,
          k < 4 ? strap ^ (4'h1 << k) : strap,
          {DPC_OP_WR_WIPER, 4'h0}, ~wip[0]);
      chk(acks, 2'h0);
      chk(t0, tap(wip[0]));
    end
    // each slot number on a random pot: guarded write refused, then real write with polling
    for (i = 0; i < 8; i++) begin
      g = i & 1;
      guard_n = g[0];
      p = $random(seed) & 1;
      v = 8'($random(seed));
      cmd(DPC_TYPE_CODE, strap, {DPC_OP_WR_SLOT, i[2:1], 1'b0, p[0]}, v);
      chk(busy, g[0]);
      if (g) begin
        slot[p][i/2] = v;
        u_mst.start();
        u_mst.wr({DPC_TYPE_CODE, strap}, a);
        u_mst.stop();
        chk(a, 1'b0);
        for (k = 0; k < 1000 && busy; k++) begin
          @(posedge mclk);
          #1;
        end
        u_mst.start();
        u_mst.wr({DPC_TYPE_CODE, strap}, a);
        u_mst.stop();
        chk(a, 1'b1);
      end
      cmd(DPC_TYPE_CODE, strap, {DPC_OP_RD_SLOT, i[2:1], 1'b0, p[0]}, 8'h00);
      chk(q, slot[p][i/2]);
    end
    give_verdict();
  end
endmodule
